// ---- hw/gcrl_pkg.sv ----
// Constants and types for the display command decoder and reset sequencer
package gcrl_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned REJECT_US = 5;
  localparam int unsigned ACCEPT_US = 9;
  localparam int unsigned LOAD_SLPIN_MS = 5;
  localparam int unsigned LOAD_SLPOUT_MS = 120;
  localparam int unsigned REJECT_CYC = (REJECT_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned ACCEPT_CYC = (ACCEPT_US * CLK_HZ) / 1_000_000;
  localparam int unsigned LOAD_SLPIN_CYC = LOAD_SLPIN_MS * (CLK_HZ / 1000);
  localparam int unsigned LOAD_SLPOUT_CYC = LOAD_SLPOUT_MS * (CLK_HZ / 1000);
  localparam int FILT_W = 8;
  localparam int LOAD_W = 24;
  localparam int PAGE_W = 4;
  localparam int COL_W = 8;
  // Opcode values and masks of the instruction path
  localparam logic [7:0] M_BIT0 = 8'hFE;
  localparam logic [7:0] M_NIB = 8'hF0;
  localparam logic [7:0] M_LOW3 = 8'hF8;
  localparam logic [7:0] M_LOW6 = 8'hC0;
  localparam logic [7:0] M_COM = 8'hF7;
  localparam logic [7:0] M_FULL = 8'hFF;
  localparam logic [7:0] OP_DISP = 8'hAE;
  localparam logic [7:0] OP_START = 8'h40;
  localparam logic [7:0] OP_PAGE = 8'hB0;
  localparam logic [7:0] OP_COLH = 8'h10;
  localparam logic [7:0] OP_COLL = 8'h00;
  localparam logic [7:0] OP_SEG = 8'hA0;
  localparam logic [7:0] OP_INV = 8'hA6;
  localparam logic [7:0] OP_ALLON = 8'hA4;
  localparam logic [7:0] OP_BIAS = 8'hA2;
  localparam logic [7:0] OP_RMW = 8'hE0;
  localparam logic [7:0] OP_END = 8'hEE;
  localparam logic [7:0] OP_SWRST = 8'hE2;
  localparam logic [7:0] OP_COM = 8'hC0;
  localparam logic [7:0] OP_PWR = 8'h28;
  localparam logic [7:0] OP_RR = 8'h20;
  localparam logic [7:0] OP_EV = 8'h81;
  localparam logic [7:0] OP_SLEEP = 8'hAC;
  localparam logic [7:0] OP_BOOST = 8'hF8;
  localparam int BIT_COM = 3;
  localparam int PWR_BOOST = 2;
  localparam int PWR_REG = 1;
  localparam int PWR_FOL = 0;
  // Status byte layout
  localparam int ST_BUSY = 7;
  localparam int ST_SEG = 6;
  localparam int ST_RST = 4;
  // Default settings, also the values reloaded from nonvolatile storage
  localparam logic [2:0] RR_RST = 3'h4;
  localparam logic [5:0] EV_RST = 6'h20;
  localparam logic [1:0] BL_RST = 2'h0;
  localparam logic [5:0] START_RST = 6'h00;
  typedef enum logic [1:0] {CMD_IDLE, CMD_EV, CMD_BL} gcrl_cmd_t;
  typedef enum logic [1:0] {HR_RUN, HR_HELD, HR_LOAD} gcrl_hr_t;
endpackage

// ---- hw/gcrl_core.sv ----
// Display command decoder, display RAM and hardware reset sequencer
`timescale 1ns/10ps
module gcrl_core
  import gcrl_pkg::*;
#(
  parameter int unsigned LOAD_SLPIN_CYC_P = LOAD_SLPIN_CYC,
  parameter int unsigned LOAD_SLPOUT_CYC_P = LOAD_SLPOUT_CYC
)
(
  input logic ref_clk,
  input logic nrst,
  input logic hwResetLineN,
  input logic cmdDataSelect,
  input logic [7:0] wrData,
  input logic wrStrobe,
  input logic rdStrobe,
  output logic [7:0] rdData,
  output logic displayOn,
  output logic [5:0] startLine,
  output logic segReverse,
  output logic comReverse,
  output logic negativeImage,
  output logic allPixelsOn,
  output logic biasChoice,
  output logic boosterOn,
  output logic regulatorOn,
  output logic followerOn,
  output logic [2:0] regulationRatio,
  output logic [5:0] contrastStep,
  output logic sleepSelect,
  output logic [1:0] pumpMultiplier,
  output logic powerSave,
  output logic panelBlank,
  output logic nvmLoading
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic opIs(input logic [7:0] b, input logic [7:0] op, input logic [7:0] m);
    return (b & m) == op;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic rstS1_q;
  logic rstS2_q;
  gcrl_hr_t hrSt_q;
  logic [FILT_W-1:0] fltCnt_q;
  logic [LOAD_W-1:0] loadCnt_q;
  logic [LOAD_W-1:0] loadLim;
  logic loadLong_q;
  logic held_q;
  logic loading_q;
  logic blank_q;
  logic busy;
  logic hrDefault;
  gcrl_cmd_t cmdSt_q;
  logic insWr;
  logic datWr;
  logic datRd;
  logic idleWr;
  logic swReset;
  logic displayOn_q;
  logic [5:0] startLine_q;
  logic segReverse_q;
  logic comReverse_q;
  logic negativeImage_q;
  logic allPixelsOn_q;
  logic biasChoice_q;
  logic boosterOn_q;
  logic regulatorOn_q;
  logic followerOn_q;
  logic [2:0] regulationRatio_q;
  logic [5:0] contrastStep_q;
  logic sleepSelect_q;
  logic [1:0] pumpMultiplier_q;
  logic powerSave_q;
  logic rmw_q;
  logic [PAGE_W-1:0] page_q;
  logic [COL_W-1:0] col_q;
  logic [7:0] rdData_q;
  logic [7:0] ram [0:(1 << (PAGE_W + COL_W)) - 1];
  logic [7:0] status;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rstS1_q <= 1'h1;
      rstS2_q <= 1'h1;
    end
    else
    begin
      rstS1_q <= hwResetLineN;
      rstS2_q <= rstS1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin reset sequencer: filter, hold, reload
  assign loadLim = loadLong_q ? LOAD_W'(LOAD_SLPOUT_CYC_P - 1) : LOAD_W'(LOAD_SLPIN_CYC_P - 1);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      hrSt_q <= HR_RUN;
      fltCnt_q <= '0;
      loadCnt_q <= '0;
      loadLong_q <= 1'h0;
      held_q <= 1'h0;
      loading_q <= 1'h0;
      blank_q <= 1'h0;
    end
    else
    begin
      case (hrSt_q)
        HR_RUN, HR_LOAD:
        begin
          if (!rstS2_q)
          begin
            // One threshold inside the 5us..9us band serves both limits
            if (fltCnt_q == FILT_W'(REJECT_CYC - 1))
            begin
              hrSt_q <= HR_HELD;
              fltCnt_q <= '0;
              held_q <= 1'h1;
              loading_q <= 1'h0;
              blank_q <= 1'h1;
              loadLong_q <= sleepSelect_q;
            end
            else
            begin
              fltCnt_q <= fltCnt_q + FILT_W'(1);
            end
          end
          else
          begin
            fltCnt_q <= '0;
          end
          if (hrSt_q == HR_LOAD && (rstS2_q || fltCnt_q != FILT_W'(REJECT_CYC - 1)))
          begin
            if (loadCnt_q == loadLim)
            begin
              hrSt_q <= HR_RUN;
              loading_q <= 1'h0;
              blank_q <= 1'h0;
            end
            else
            begin
              loadCnt_q <= loadCnt_q + LOAD_W'(1);
            end
          end
        end
        HR_HELD:
        begin
          // High spikes shorter than the filter time do not end the reset
          if (rstS2_q)
          begin
            if (fltCnt_q == FILT_W'(REJECT_CYC - 1))
            begin
              hrSt_q <= HR_LOAD;
              fltCnt_q <= '0;
              held_q <= 1'h0;
              loading_q <= 1'h1;
              loadCnt_q <= '0;
            end
            else
            begin
              fltCnt_q <= fltCnt_q + FILT_W'(1);
            end
          end
          else
          begin
            fltCnt_q <= '0;
          end
        end
        default:
        begin
          hrSt_q <= HR_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode; instruction and data writes are dropped while busy
  assign busy = held_q | loading_q;
  assign hrDefault = busy;
  assign insWr = wrStrobe & ~cmdDataSelect & ~busy;
  assign datWr = wrStrobe & cmdDataSelect & ~busy;
  assign datRd = rdStrobe & cmdDataSelect & ~busy;
  assign idleWr = insWr & (cmdSt_q == CMD_IDLE);
  assign swReset = idleWr & opIs(wrData, OP_SWRST, M_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Two-byte command tracking
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || hrDefault)
    begin
      cmdSt_q <= CMD_IDLE;
    end
    else if (insWr)
    begin
      case (cmdSt_q)
        CMD_IDLE:
        begin
          if (opIs(wrData, OP_EV, M_FULL))
            cmdSt_q <= CMD_EV;
          else if (opIs(wrData, OP_BOOST, M_FULL))
            cmdSt_q <= CMD_BL;
        end
        default:
        begin
          cmdSt_q <= CMD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings; unknown opcodes, test opcode included, change nothing
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || hrDefault || swReset)
    begin
      displayOn_q <= 1'h0;
      startLine_q <= START_RST;
      segReverse_q <= 1'h0;
      comReverse_q <= 1'h0;
      negativeImage_q <= 1'h0;
      allPixelsOn_q <= 1'h0;
      biasChoice_q <= 1'h0;
      boosterOn_q <= 1'h0;
      regulatorOn_q <= 1'h0;
      followerOn_q <= 1'h0;
      regulationRatio_q <= RR_RST;
      contrastStep_q <= EV_RST;
      sleepSelect_q <= 1'h0;
      pumpMultiplier_q <= BL_RST;
    end
    else if (idleWr)
    begin
      if (opIs(wrData, OP_DISP, M_BIT0))
        displayOn_q <= wrData[0];
      if (opIs(wrData, OP_START, M_LOW6))
        startLine_q <= wrData[5:0];
      if (opIs(wrData, OP_SEG, M_BIT0))
        segReverse_q <= wrData[0];
      if (opIs(wrData, OP_COM, M_COM))
        comReverse_q <= wrData[BIT_COM];
      if (opIs(wrData, OP_INV, M_BIT0))
        negativeImage_q <= wrData[0];
      if (opIs(wrData, OP_ALLON, M_BIT0))
        allPixelsOn_q <= wrData[0];
      if (opIs(wrData, OP_BIAS, M_BIT0))
        biasChoice_q <= wrData[0];
      if (opIs(wrData, OP_PWR, M_LOW3))
      begin
        boosterOn_q <= wrData[PWR_BOOST];
        regulatorOn_q <= wrData[PWR_REG];
        followerOn_q <= wrData[PWR_FOL];
      end
      if (opIs(wrData, OP_RR, M_LOW3))
        regulationRatio_q <= wrData[2:0];
      if (opIs(wrData, OP_SLEEP, M_BIT0))
        sleepSelect_q <= wrData[0];
    end
    else if (insWr && cmdSt_q == CMD_EV)
    begin
      contrastStep_q <= wrData[5:0];
    end
    else if (insWr && cmdSt_q == CMD_BL)
    begin
      pumpMultiplier_q <= wrData[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power save follows the compound state one cycle late
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      powerSave_q <= 1'h0;
    else
      powerSave_q <= ~displayOn_q & allPixelsOn_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page and column pointers, read-modify-write mode
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || hrDefault || swReset)
    begin
      rmw_q <= 1'h0;
      page_q <= '0;
      col_q <= '0;
    end
    else
    begin
      if (idleWr && opIs(wrData, OP_RMW, M_FULL))
        rmw_q <= 1'h1;
      else if (idleWr && opIs(wrData, OP_END, M_FULL))
        rmw_q <= 1'h0;
      if (idleWr && opIs(wrData, OP_PAGE, M_NIB))
        page_q <= wrData[PAGE_W-1:0];
      if (idleWr && opIs(wrData, OP_COLH, M_NIB))
        col_q <= {wrData[3:0], col_q[3:0]};
      else if (idleWr && opIs(wrData, OP_COLL, M_NIB))
        col_q <= {col_q[7:4], wrData[3:0]};
      else if (datWr || (datRd && !rmw_q))
        col_q <= col_q + COL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display RAM; not cleared by any reset
  always_ff @(posedge ref_clk)
  begin
    if (datWr)
      ram[{page_q, col_q}] <= wrData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: answer in the cycle after the strobe
  assign status = {busy, segReverse_q, 1'h0, held_q, 4'h0};

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      rdData_q <= 8'h00;
    else if (rdStrobe && cmdDataSelect)
      rdData_q <= ram[{page_q, col_q}];
    else if (rdStrobe)
      rdData_q <= status;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdData = rdData_q;
  assign displayOn = displayOn_q;
  assign startLine = startLine_q;
  assign segReverse = segReverse_q;
  assign comReverse = comReverse_q;
  assign negativeImage = negativeImage_q;
  assign allPixelsOn = allPixelsOn_q;
  assign biasChoice = biasChoice_q;
  assign boosterOn = boosterOn_q;
  assign regulatorOn = regulatorOn_q;
  assign followerOn = followerOn_q;
  assign regulationRatio = regulationRatio_q;
  assign contrastStep = contrastStep_q;
  assign sleepSelect = sleepSelect_q;
  assign pumpMultiplier = pumpMultiplier_q;
  assign powerSave = powerSave_q;
  assign panelBlank = blank_q;
  assign nvmLoading = loading_q;

endmodule

// ---- tb/gcrl_props.sv ----
// Port-level checks for the display command decoder
`timescale 1ns/10ps
module gcrl_props
#(
  parameter int unsigned LOAD_SLPIN_CYC_P = 20,
  parameter int unsigned LOAD_SLPOUT_CYC_P = 40
)
(
  input logic ref_clk,
  input logic nrst,
  input logic hwResetLineN,
  input logic cmdDataSelect,
  input logic [7:0] wrData,
  input logic wrStrobe,
  input logic rdStrobe,
  input logic [7:0] rdData,
  input logic displayOn,
  input logic [5:0] startLine,
  input logic segReverse,
  input logic allPixelsOn,
  input logic [2:0] regulationRatio,
  input logic [5:0] contrastStep,
  input logic powerSave,
  input logic panelBlank,
  input logic nvmLoading
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  int unsigned loadCnt_q;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || !nvmLoading)
      loadCnt_q <= 0;
    else
      loadCnt_q <= loadCnt_q + 1;
  end
  // Pin high long enough that no reset acceptance can land on this edge
  sequence s_quiet;
    hwResetLineN [*3] ##0 !panelBlank;
  endsequence
  sequence s_cmd(logic [7:0] m, logic [7:0] v);
    wrStrobe && !cmdDataSelect && ((wrData & m) == v);
  endsequence
  property p_disp;
    s_quiet ##0 s_cmd(8'hFE, 8'hAE) |=> displayOn == $past(wrData[0]);
  endproperty
  a_disp: assert property (p_disp) else $error("display switch wrong");
  property p_start;
    s_quiet ##0 s_cmd(8'hC0, 8'h40) |=> startLine == $past(wrData[5:0]);
  endproperty
  a_start: assert property (p_start) else $error("start line wrong");
  property p_ev;
    s_quiet ##0 s_cmd(8'hFF, 8'h81) ##[1:3] s_cmd(8'h00, 8'h00) |=> contrastStep == $past(wrData[5:0]);
  endproperty
  a_ev: assert property (p_ev) else $error("contrast byte wrong");
  property p_status;
    rdStrobe && !cmdDataSelect |=> rdData[5] == 1'b0 && rdData[3:0] == 4'h0 && rdData[6] == $past(segReverse)
      && rdData[7] == $past(panelBlank);
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_blank;
    nvmLoading |-> panelBlank;
  endproperty
  a_blank: assert property (p_blank) else $error("reload not blanked");
  property p_dflt;
    panelBlank [*2] |-> !displayOn && contrastStep == 6'h20 && regulationRatio == 3'h4;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults not held");
  property p_psave;
    (!displayOn && allPixelsOn) [*2] |-> powerSave;
  endproperty
  a_psave: assert property (p_psave) else $error("power save missing");
  property p_reject;
    $rose(panelBlank) |-> $past(hwResetLineN, 5) == 1'b0 && $past(hwResetLineN, 45) == 1'b0;
  endproperty
  a_reject: assert property (p_reject) else $error("short pulse accepted");
  property p_load;
    $fell(nvmLoading) && !panelBlank |-> loadCnt_q == LOAD_SLPIN_CYC_P || loadCnt_q == LOAD_SLPOUT_CYC_P;
  endproperty
  a_load: assert property (p_load) else $error("reload length wrong");
endmodule

// ---- tb/gcrl_host.sv ----
// Host processor model driving the register port
`timescale 1ns/10ps
module gcrl_host
(
  input logic ref_clk,
  input logic [7:0] rdData,
  output logic cmdDataSelect,
  output logic [7:0] wrData,
  output logic wrStrobe,
  output logic rdStrobe
);
  initial
  begin
    cmdDataSelect = 1'b0;
    wrData = 8'h00;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end
  // Never issues the factory test opcode; callers pick only decoded values
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge ref_clk);
    cmdDataSelect <= sel;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    // Released bus shows the inverse so stale data cannot pass for valid
    wrData <= ~d;
    #1;
  endtask
  task automatic rd(input logic sel, output logic [7:0] d);
    @(posedge ref_clk);
    cmdDataSelect <= sel;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    @(posedge ref_clk);
    d = rdData;
  endtask
endmodule

// ---- tb/tb_gcrl_core.sv ----
// Self-checking bench for the display command decoder and reset sequencer
`timescale 1ns/10ps
module tb_gcrl_core;
  import gcrl_pkg::*;
  logic ref_clk, nrst, hwResetLineN, cmdDataSelect, wrStrobe, rdStrobe;
  logic [7:0] wrData, rdData;
  logic displayOn, segReverse, comReverse, negativeImage, allPixelsOn, biasChoice;
  logic boosterOn, regulatorOn, followerOn, sleepSelect, powerSave, panelBlank, nvmLoading;
  logic [5:0] startLine, contrastStep;
  logic [2:0] regulationRatio;
  logic [1:0] pumpMultiplier;
  logic [15:0] flags;
  int err_count, tests_run;
  assign flags = {displayOn, segReverse, comReverse, negativeImage, allPixelsOn, biasChoice, boosterOn,
    regulatorOn, followerOn, sleepSelect, regulationRatio, 3'h0};
  // Each opcode and the whole flag set expected after it
  localparam logic [7:0] OPS [17] = '{8'hAF, 8'hA1, 8'hC8, 8'hA7, 8'hA5, 8'hA3, 8'h2C, 8'h2B, 8'hAD,
    8'h23, 8'hA6, 8'hA4, 8'hAE, 8'hA0, 8'hC0, 8'hA2, 8'hAC};
  localparam logic [15:0] EXP [17] = '{16'h8020, 16'hC020, 16'hE020, 16'hF020, 16'hF820, 16'hFC20,
    16'hFE20, 16'hFDA0, 16'hFDE0, 16'hFDD8, 16'hEDD8, 16'hE5D8, 16'h65D8, 16'h25D8, 16'h05D8, 16'h01D8, 16'h0198};
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  gcrl_host u_host (.ref_clk(ref_clk), .rdData(rdData), .cmdDataSelect(cmdDataSelect), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));
  gcrl_core #(.LOAD_SLPIN_CYC_P(20), .LOAD_SLPOUT_CYC_P(40)) DUT (.ref_clk(ref_clk), .nrst(nrst),
    .hwResetLineN(hwResetLineN), .cmdDataSelect(cmdDataSelect), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .displayOn(displayOn), .startLine(startLine),
    .segReverse(segReverse), .comReverse(comReverse), .negativeImage(negativeImage),
    .allPixelsOn(allPixelsOn), .biasChoice(biasChoice), .boosterOn(boosterOn), .regulatorOn(regulatorOn),
    .followerOn(followerOn), .regulationRatio(regulationRatio), .contrastStep(contrastStep),
    .sleepSelect(sleepSelect), .pumpMultiplier(pumpMultiplier), .powerSave(powerSave),
    .panelBlank(panelBlank), .nvmLoading(nvmLoading));
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ci(input logic [7:0] d);
    u_host.wr(1'b0, d);
  endtask
  task automatic cd(input logic [7:0] d);
    u_host.wr(1'b1, d);
  endtask
  task automatic rk(input logic sel, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(sel, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic t_flags;
    for (int i = 0; i < 17; i++)
    begin
      ci(OPS[i]);
      chk(flags, EXP[i]);
    end
    ci(8'h6A);
    chk(16'(startLine), 16'h002A);
    ci(8'hA5);
    // Power save trails the settings by one edge
    repeat (2) @(negedge ref_clk);
    chk(16'(powerSave), 16'h0001);
    ci(8'hA1);
    rk(1'b0, 8'h40);
    ci(8'hE2);
    chk(flags, 16'h0020);
    chk(16'(startLine), 16'h0000);
    rk(1'b0, 8'h00);
  endtask
  task automatic t_pair;
    ci(8'h81);
    ci(8'hA1);
    chk(16'({contrastStep, segReverse}), 16'h0042);
    ci(8'h81);
    cd(8'h99);
    ci(8'h15);
    chk(16'(contrastStep), 16'h0015);
    for (int i = 0; i < 4; i++)
    begin
      ci(8'hF8);
      ci(8'hFC | 8'(i));
      chk(16'(pumpMultiplier), 16'(i));
    end
  endtask
  task automatic t_ram;
    ci(8'hB3);
    ci(8'h11);
    ci(8'h02);
    cd(8'h3C);
    cd(8'hC3);
    ci(8'hB4);
    ci(8'h02);
    cd(8'h77);
    ci(8'hB3);
    ci(8'h10);
    ci(8'h02);
    cd(8'hE1);
    ci(8'h11);
    ci(8'h02);
    rk(1'b1, 8'h3C);
    rk(1'b1, 8'hC3);
    ci(8'h02);
    ci(8'hE0);
    rk(1'b1, 8'h3C);
    rk(1'b1, 8'h3C);
    cd(8'h5A);
    rk(1'b1, 8'hC3);
    ci(8'hEE);
    ci(8'h02);
    rk(1'b1, 8'h5A);
    rk(1'b1, 8'hC3);
    ci(8'hB4);
    ci(8'h02);
    rk(1'b1, 8'h77);
  endtask
  task automatic pin(input int k);
    @(posedge ref_clk);
    hwResetLineN <= 1'b0;
    repeat (k) @(posedge ref_clk);
    hwResetLineN <= 1'b1;
  endtask
  task automatic t_pin(input logic sleepOut, input int expLoad);
    int n;
    ci({7'h56, sleepOut});
    ci(8'hAF);
    pin(30);
    repeat (60) @(posedge ref_clk);
    chk(16'({panelBlank, displayOn}), 16'h0001);
    pin(70);
    chk(16'({panelBlank, displayOn}), 16'h0002);
    rk(1'b0, 8'h90);
    // Sample on the falling edge so the count never races the flop update
    n = 0;
    while (nvmLoading !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (nvmLoading === 1'b1 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n), 16'(expLoad));
    if (n == 0 || n >= 1000)
      close_out();
    @(negedge ref_clk);
    chk(16'(panelBlank), 16'h0000);
    chk(flags, 16'h0020);
    // Commands only once the reload has finished
    ci(8'hAF);
    chk(16'(displayOn), 16'h0001);
  endtask
  initial
  begin
    nrst = 1'b0;
    hwResetLineN = 1'b1;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    t_flags();
    t_pair();
    t_ram();
    t_pin(1'b1, 40);
    t_pin(1'b0, 20);
    close_out();
  end
endmodule
bind gcrl_core gcrl_props #(.LOAD_SLPIN_CYC_P(LOAD_SLPIN_CYC_P), .LOAD_SLPOUT_CYC_P(LOAD_SLPOUT_CYC_P)) u_props (
  .ref_clk(ref_clk), .nrst(nrst), .hwResetLineN(hwResetLineN), .cmdDataSelect(cmdDataSelect),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .displayOn(displayOn),
  .startLine(startLine), .segReverse(segReverse), .allPixelsOn(allPixelsOn),
  .regulationRatio(regulationRatio), .contrastStep(contrastStep), .powerSave(powerSave),
  .panelBlank(panelBlank), .nvmLoading(nvmLoading));
